// ---- inc/mixer_ctl_pkg.sv ----
/*
  Constants and types shared by the serial control port of the 8x2 mixer.
  Assumes a compiler with SystemVerilog packed structs.
*/
`default_nettype none
package mixer_ctl_pkg;
  // ==========================================
  // Sizes
  localparam int NUM_CHAN = 8;
  localparam int BYTE_W = 8;
  localparam int CHAN_W = 3;
  localparam int ATTEN_W = 6;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

  // ==========================================
  // Control byte layout
  localparam int ADDR_FLAG_BIT = 7;
  localparam int CHAN_LSB = 0;
  localparam int ROUTE_LEFT_BIT = 3;
  localparam int ROUTE_RIGHT_BIT = 4;
  localparam int MUTE_BIT = 6;
  localparam int ATTEN_LSB = 0;

  // ==========================================
  // Channel setting
  typedef struct packed {
    logic mute;
    logic [ATTEN_W-1:0] atten;
    logic to_left;
    logic to_right;
  } chan_setting_t;

  // Power-up: everything muted, full attenuation, routed nowhere
  localparam chan_setting_t CHAN_RESET = '{mute: 1'b1, atten: 6'h3f, to_left: 1'b0,
                                           to_right: 1'b0};

  typedef struct packed {
    logic write_n;
    logic apply_n;
    logic three_wire;
    logic toggle;
  } link_levels_t;

  localparam link_levels_t LEVELS_RESET = '{write_n: 1'b1, apply_n: 1'b1,
                                            three_wire: 1'b0, toggle: 1'b0};
endpackage
`default_nettype wire

// ---- logic/level_sync.sv ----
/*
  Two flip-flop synchroniser for a bundle of levels.
  Assumes each bit is a slow level or a toggle; no multi-bit coherence.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // ==========================================
  // First stage is read only by the second
  always_comb begin
    next_meta = resetn ? d : RESET_VAL;
    next_q = resetn ? meta : RESET_VAL;
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule
`default_nettype wire

// ---- logic/mixer_serial_control_port.sv ----
/*
  Serial control port of an 8-input, 2-output mixer: shifter on the host
  serial clock, decoder and channel settings on sys_clk.
  Assumes the host keeps the serial timing, that the serial clock only
  runs while the write strobe is low, and that each finished byte stands
  for at least four sys_clk periods before the next one completes.
*/
// Summary of operation
// - Sample data on serial clock rising edge
// - Top bit set addresses, clear sets gain
// - Three-wire mode applies at write end
// - Attenuation 0 to 63 dB plus mute
// - Each channel routes left, right, both or neither
// - Serial data output feeds daisy chain
// - Data output updates on rising edge
`timescale 1ns/1ps
`default_nettype none
module mixer_serial_control_port (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic write_n,
  input wire logic apply_strobe_n,
  input wire logic three_wire,
  output logic data_out,
  output mixer_ctl_pkg::chan_setting_t [mixer_ctl_pkg::NUM_CHAN-1:0] chan_setting
);
  // ==========================================
  // Link side, on the serial clock
  // Write high clears the shifter, since the clock may stop between frames
  logic [mixer_ctl_pkg::BYTE_W-1:0] shift;
  logic [mixer_ctl_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [mixer_ctl_pkg::BYTE_W-1:0] next_shift;
  logic [mixer_ctl_pkg::BIT_CNT_W-1:0] next_bit_cnt;
  logic next_data_out;
  logic [mixer_ctl_pkg::BYTE_W-1:0] byte_hold = '0;
  logic byte_toggle = 1'b0;
  logic [mixer_ctl_pkg::BYTE_W-1:0] next_byte_hold;
  logic next_byte_toggle;
  logic byte_done;
  // High from the first rise of a frame, so checks never look back past a frame start
  logic in_frame;
  logic next_in_frame;

  always_comb begin
    next_shift = {shift[mixer_ctl_pkg::BYTE_W-2:0], ser_data};
    next_bit_cnt = bit_cnt + 3'h1;
    next_data_out = shift[mixer_ctl_pkg::BYTE_W-1];
    byte_done = (bit_cnt == mixer_ctl_pkg::LAST_BIT);
    next_byte_hold = byte_done ? next_shift : byte_hold;
    next_byte_toggle = byte_toggle ^ byte_done;
    next_in_frame = 1'b1;
  end

  always_ff @(posedge ser_clk or posedge write_n) begin
    if (write_n) begin
      shift <= '0;
      bit_cnt <= '0;
      data_out <= 1'b0;
      in_frame <= 1'b0;
    end else begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      data_out <= next_data_out;
      in_frame <= next_in_frame;
    end
  end

  // Held byte stays put until the next byte ends; a fast link clock must
  // pause between bytes, or the decoder reads a newer byte than it was told of
  always_ff @(posedge ser_clk) begin
    byte_hold <= next_byte_hold;
    byte_toggle <= next_byte_toggle;
  end

  ser_shift_a: assert property (@(posedge ser_clk) disable iff (write_n)
    in_frame |-> shift[0] == $past(ser_data))
    else $error("shifter missed the sampled data bit");
  chain_out_a: assert property (@(posedge ser_clk) disable iff (write_n)
    in_frame |-> data_out == $past(shift[mixer_ctl_pkg::BYTE_W-1]))
    else $error("data output did not follow the shifter");
  chain_delay_a: assert property (@(posedge ser_clk) disable iff (write_n)
    in_frame[*8] ##1 in_frame |-> data_out == $past(ser_data, 9))
    else $error("daisy chain delay is not nine clocks");

  // ==========================================
  // Crossing into sys_clk
  mixer_ctl_pkg::link_levels_t raw_levels;
  mixer_ctl_pkg::link_levels_t levels;

  assign raw_levels = '{write_n: write_n, apply_n: apply_strobe_n,
                        three_wire: three_wire, toggle: byte_toggle};

  level_sync #(
    .W($bits(mixer_ctl_pkg::link_levels_t)),
    .RESET_VAL(mixer_ctl_pkg::LEVELS_RESET)
  ) u_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .d(raw_levels),
    .q(levels)
  );

  // ==========================================
  // Decoder on sys_clk
  function automatic logic [mixer_ctl_pkg::CHAN_W-1:0] chan_of(
      input logic [mixer_ctl_pkg::BYTE_W-1:0] b);
    chan_of = b[mixer_ctl_pkg::CHAN_LSB +: mixer_ctl_pkg::CHAN_W];
  endfunction

  function automatic logic is_addr(input logic [mixer_ctl_pkg::BYTE_W-1:0] b);
    is_addr = b[mixer_ctl_pkg::ADDR_FLAG_BIT];
  endfunction

  mixer_ctl_pkg::link_levels_t prev;
  logic addr_valid;
  logic [mixer_ctl_pkg::CHAN_W-1:0] addr;
  mixer_ctl_pkg::chan_setting_t [mixer_ctl_pkg::NUM_CHAN-1:0] pending;
  mixer_ctl_pkg::link_levels_t next_prev;
  logic next_addr_valid;
  logic [mixer_ctl_pkg::CHAN_W-1:0] next_addr;
  mixer_ctl_pkg::chan_setting_t [mixer_ctl_pkg::NUM_CHAN-1:0] next_pending;
  mixer_ctl_pkg::chan_setting_t [mixer_ctl_pkg::NUM_CHAN-1:0] next_chan_setting;
  logic byte_evt;
  logic write_start;
  logic write_end;
  logic apply_evt;

  always_comb begin
    byte_evt = levels.toggle ^ prev.toggle;
    write_start = prev.write_n & ~levels.write_n;
    write_end = ~prev.write_n & levels.write_n;
    // Three-wire: load pin follows write, so the write end is the load
    apply_evt = levels.three_wire ? write_end : (~prev.apply_n & levels.apply_n);
    next_prev = levels;
    next_addr_valid = addr_valid & ~write_start;
    next_addr = addr;
    next_pending = pending;
    if (byte_evt) begin
      if (is_addr(byte_hold)) begin
        next_addr_valid = 1'b1;
        next_addr = chan_of(byte_hold);
        next_pending[chan_of(byte_hold)].to_left = byte_hold[mixer_ctl_pkg::ROUTE_LEFT_BIT];
        next_pending[chan_of(byte_hold)].to_right = byte_hold[mixer_ctl_pkg::ROUTE_RIGHT_BIT];
      end else if (addr_valid) begin
        // Gain bytes with no address in this frame are dropped
        next_pending[addr].mute = byte_hold[mixer_ctl_pkg::MUTE_BIT];
        next_pending[addr].atten = byte_hold[mixer_ctl_pkg::ATTEN_LSB +: mixer_ctl_pkg::ATTEN_W];
      end
    end
    // Apply sees a byte finishing in the same cycle
    next_chan_setting = apply_evt ? next_pending : chan_setting;
    if (!resetn) begin
      next_prev = mixer_ctl_pkg::LEVELS_RESET;
      next_addr_valid = 1'b0;
      next_addr = '0;
      next_pending = {mixer_ctl_pkg::NUM_CHAN{mixer_ctl_pkg::CHAN_RESET}};
      next_chan_setting = {mixer_ctl_pkg::NUM_CHAN{mixer_ctl_pkg::CHAN_RESET}};
    end
  end

  always_ff @(posedge sys_clk) begin
    prev <= next_prev;
    addr_valid <= next_addr_valid;
    addr <= next_addr;
    pending <= next_pending;
    chan_setting <= next_chan_setting;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  addr_select_a: assert property (
    byte_evt && is_addr(byte_hold) |=> addr_valid && addr == $past(chan_of(byte_hold)))
    else $error("address byte did not select its channel");
  gain_level_a: assert property (
    byte_evt && !is_addr(byte_hold) && addr_valid |=>
      pending[$past(addr)].atten == $past(byte_hold[mixer_ctl_pkg::ATTEN_W-1:0])
      && pending[$past(addr)].mute == $past(byte_hold[mixer_ctl_pkg::MUTE_BIT]))
    else $error("gain byte not stored for the selected channel");
  route_set_a: assert property (
    byte_evt && is_addr(byte_hold) |=>
      pending[addr].to_left == $past(byte_hold[mixer_ctl_pkg::ROUTE_LEFT_BIT])
      && pending[addr].to_right == $past(byte_hold[mixer_ctl_pkg::ROUTE_RIGHT_BIT]))
    else $error("routing not stored for the addressed channel");
  three_wire_a: assert property (
    levels.three_wire && write_end && !byte_evt |=> chan_setting == $past(pending))
    else $error("three-wire write end did not apply settings");
  apply_hold_a: assert property (
    !apply_evt |=> $stable(chan_setting))
    else $error("settings changed without a load");
  four_wire_a: assert property (
    !levels.three_wire && !prev.apply_n && levels.apply_n && !byte_evt |=>
      chan_setting == $past(pending))
    else $error("load pulse did not apply settings");
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
/*
  Host side of the mixer serial link: clock, data and strobes.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic write_n,
  output logic apply_strobe_n
);
  // Fast link clock in bursts: it stands still after each byte so the
  // held byte can cross into sys_clk before the next one lands
  localparam time HALF = 6ns;
  localparam time GAP = 200ns;
  logic idle_hi = 1'b0;
  logic tied = 1'b0;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b1;
    write_n = 1'b1;
    apply_strobe_n = 1'b1;
  end
  // ==========================================
  // Frame of two bytes
  task automatic frame(input logic [15:0] bytes);
    ser_clk = idle_hi;
    #HALF;
    write_n = 1'b0;
    if (tied) apply_strobe_n = 1'b0;
    #HALF;
    for (int i = 15; i >= 0; i--) begin
      ser_clk = 1'b0;
      ser_data = bytes[i];
      #HALF;
      ser_clk = 1'b1;
      #HALF;
      if (i % 8 == 0) #GAP;
    end
    ser_clk = idle_hi;
    // Released data line shows the inverse, never a stale value
    ser_data = ~ser_data;
    #HALF;
    write_n = 1'b1;
    if (tied) apply_strobe_n = 1'b1;
    #300ns;
  endtask
  task automatic pulse();
    apply_strobe_n = 1'b0;
    #300ns;
    apply_strobe_n = 1'b1;
    #300ns;
  endtask
endmodule
`default_nettype wire

// ---- verif/mixer_serial_control_port_tb.sv ----
/*
  Self-checking bench for the mixer serial control port.
  Assumes host_model drives every serial pin.
*/
`timescale 1ns/1ps
`default_nettype none
module mixer_serial_control_port_tb;
  typedef mixer_ctl_pkg::chan_setting_t cs_t;
  typedef struct packed {
    logic tw;
    logic idle_hi;
    logic [2:0] chan;
    cs_t exp;
  } row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic three_wire = 1'b0;
  wire ser_clk;
  wire ser_data;
  wire write_n;
  wire apply_strobe_n;
  wire data_out;
  cs_t [mixer_ctl_pkg::NUM_CHAN-1:0] chan_setting;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int bitn = 0;
  logic [9:0] hist = 10'h000;
  row_t rows[6] = '{
    '{1'b0, 1'b0, 3'h0, '{1'b0, 6'h00, 1'b1, 1'b0}},
    '{1'b0, 1'b1, 3'h7, '{1'b0, 6'h3f, 1'b0, 1'b1}},
    '{1'b1, 1'b0, 3'h3, '{1'b0, 6'h15, 1'b1, 1'b1}},
    '{1'b1, 1'b1, 3'h6, '{1'b1, 6'h2a, 1'b0, 1'b0}},
    '{1'b0, 1'b0, 3'h1, '{1'b1, 6'h00, 1'b1, 1'b1}},
    '{1'b1, 1'b0, 3'h4, '{1'b0, 6'h3e, 1'b1, 1'b0}}};
  mixer_serial_control_port u_dut (.sys_clk(sys_clk), .resetn(resetn), .ser_clk(ser_clk),
    .ser_data(ser_data), .write_n(write_n), .apply_strobe_n(apply_strobe_n),
    .three_wire(three_wire), .data_out(data_out), .chan_setting(chan_setting));
  host_model u_host (.ser_clk(ser_clk), .ser_data(ser_data), .write_n(write_n),
    .apply_strobe_n(apply_strobe_n));
  initial begin
    forever #20ns sys_clk = ~sys_clk;
  end
  // ==========================================
  // Checks and verdict
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected data_out at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_chan(input int c, input cs_t exp);
    num_checks++;
    if (chan_setting[c] !== exp) begin
      n_errors++;
      $display("unexpected ch %0d at %0t: got %h expected %h", c, $time, chan_setting[c], exp);
    end
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // After each rise the daisy output shows the bit taken eight rises earlier
  always @(posedge ser_clk) hist <= {hist[8:0], ser_data};
  always @(posedge ser_clk or posedge write_n) bitn <= write_n ? 0 : bitn + 1;
  always @(negedge ser_clk) if (!write_n && bitn > 8) check_bit(data_out, hist[8]);
  // ==========================================
  // Sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    #1ns resetn = 1'b1;
    for (int c = 0; c < 8; c++) check_chan(c, mixer_ctl_pkg::CHAN_RESET);
    $display("reset test done");
    repeat (2) @(posedge sys_clk);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      #1ns three_wire = rows[i].tw;
      u_host.idle_hi = rows[i].idle_hi;
      u_host.tied = rows[i].tw;
      u_host.frame({3'h4, rows[i].exp.to_right, rows[i].exp.to_left, rows[i].chan,
                    1'b0, rows[i].exp.mute, rows[i].exp.atten});
      if (!rows[i].tw) u_host.pulse();
      repeat (5) @(posedge sys_clk);
      check_chan(rows[i].chan, rows[i].exp);
      $display("row %0d done", i);
    end
    // Four-wire without load keeps old settings; orphan gain bytes are dropped
    #1ns three_wire = 1'b0;
    u_host.tied = 1'b0;
    u_host.frame(16'h8d15);
    repeat (10) @(posedge sys_clk);
    check_chan(5, mixer_ctl_pkg::CHAN_RESET);
    u_host.frame(16'h2a2a);
    u_host.pulse();
    repeat (5) @(posedge sys_clk);
    check_chan(5, '{1'b0, 6'h15, 1'b1, 1'b0});
    $display("hold and drop test done");
    give_verdict();
  end
endmodule
`default_nettype wire
